// file: shared/nbpr_pkg.sv
// shared constants and types of the nand page read host
package nbpr_pkg;
    // command bytes
    localparam logic [7:0] CMD_PAGE_READ = 8'h00;
    localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
    localparam logic [7:0] CMD_COLUMN_CHANGE = 8'h05;
    localparam logic [7:0] CMD_COLUMN_CONFIRM = 8'he0;
    // page geometry
    localparam int PAGE_MAIN_BYTES = 2048;
    localparam int PAGE_SPARE_BYTES = 64;
    localparam int BLOCK_PAGES = 64;
    localparam int ROW_BITS = 17;
    localparam int COL_BITS = 12;
    localparam int PLANE_ROW_BIT = 6;
    // address sequence positions
    localparam logic [2:0] STEP_CMD = 3'h0;
    localparam logic [2:0] STEP_COL_FIRST = 3'h1;
    localparam logic [2:0] STEP_COL_LAST = 3'h2;
    localparam logic [2:0] STEP_ROW_LAST = 3'h5;
    localparam logic [2:0] STEP_CONFIRM = 3'h6;
    // timing
    localparam int CLOCK_NS = 4;
    localparam int STROBE_LOW_NS = 12;
    localparam int STROBE_HIGH_NS = 12;
    localparam int EDO_LIMIT_NS = 30;
    localparam int BUSY_START_NS = 100;
    localparam int COLUMN_SETTLE_NS = 80;
    localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int BUSY_START_CYC = (BUSY_START_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int COLUMN_SETTLE_CYC = (COLUMN_SETTLE_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam bit EDO_MODE = (STROBE_LOW_NS + STROBE_HIGH_NS) < EDO_LIMIT_NS;
    // reset values
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    typedef enum logic [1:0] {NBPR_CYC_CMD, NBPR_CYC_ADDR, NBPR_CYC_READ} nbpr_kind_type;
    typedef enum logic {NBPR_OP_PAGE_READ, NBPR_OP_COLUMN_CHANGE} nbpr_op_type;
endpackage

// file: shared/nbpr_cycle_if.sv
// one bus cycle request and answer between sequencer and strobe engine
`timescale 1ns/100ps
interface nbpr_cycle_if;
    logic req;
    nbpr_pkg::nbpr_kind_type kind;
    logic [15:0] wdata;
    logic idle;
    logic done;
    logic [15:0] rdata;
    modport sequencer (output req, output kind, output wdata, input idle, input done, input rdata);
    modport engine (input req, input kind, input wdata, output idle, output done, output rdata);
endinterface

// file: hdl/nbpr_bus_cycle.sv
// strobe engine: one command, address or read cycle on the shared bus
`timescale 1ns/100ps
module nbpr_bus_cycle #(
    parameter int BUS_WIDTH = 8
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // request from sequencer
    nbpr_cycle_if.engine cyc,
    // flash pins
    output logic o_cle,
    output logic o_ale,
    output logic o_we_n,
    output logic o_read_strobe_n,
    output logic [BUS_WIDTH-1:0] o_io,
    output logic [BUS_WIDTH-1:0] o_io_oe,
    input wire logic [BUS_WIDTH-1:0] i_io
);
    // read word travels back in a 16-bit carrier
    if (BUS_WIDTH < 1 || BUS_WIDTH > 16)
    begin
        $error("engine bus width must be 1 to 16");
    end
    typedef enum logic [1:0] {E_IDLE, E_SETUP, E_LOW, E_HIGH} nbpr_eng_type;
    nbpr_eng_type state_reg;
    logic [7:0] cnt_reg;
    logic is_read_reg;
    logic [BUS_WIDTH-1:0] io_meta_reg;
    logic [BUS_WIDTH-1:0] io_sync_reg;
    logic [15:0] rdata_reg;
    logic done_reg;

    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [7:0] LOW_LOAD = 8'(nbpr_pkg::STROBE_LOW_CYC - 1);
    localparam logic [7:0] HIGH_LOAD = 8'(nbpr_pkg::STROBE_HIGH_CYC - 1);
    wire cnt_zero = (cnt_reg == COUNT_ZERO);
    // edo: bus held after the rise, so sample at the end of the high phase instead
    wire capture_now = is_read_reg && cnt_zero &&
        (nbpr_pkg::EDO_MODE ? (state_reg == E_HIGH) : (state_reg == E_LOW));

    assign cyc.idle = (state_reg == E_IDLE);
    assign cyc.done = done_reg;
    assign cyc.rdata = rdata_reg;

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            io_meta_reg <= '0;
            io_sync_reg <= '0;
        end
        else
        begin
            io_meta_reg <= i_io;
            io_sync_reg <= io_meta_reg;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_reg <= E_IDLE;
            cnt_reg <= nbpr_pkg::COUNT_RESET;
            is_read_reg <= 1'b0;
            o_cle <= 1'b0;
            o_ale <= 1'b0;
            o_we_n <= 1'b1;
            o_read_strobe_n <= 1'b1;
            o_io <= '0;
            o_io_oe <= '0;
            rdata_reg <= nbpr_pkg::WORD_RESET;
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            if (capture_now)
                rdata_reg <= 16'(io_sync_reg);
            case (state_reg)
                E_IDLE:
                    if (cyc.req)
                    begin
                        // qualifiers never both high; data cycles keep both low
                        o_cle <= (cyc.kind == nbpr_pkg::NBPR_CYC_CMD);
                        o_ale <= (cyc.kind == nbpr_pkg::NBPR_CYC_ADDR);
                        is_read_reg <= (cyc.kind == nbpr_pkg::NBPR_CYC_READ);
                        o_io <= cyc.wdata[BUS_WIDTH-1:0];
                        o_io_oe <= {BUS_WIDTH{cyc.kind != nbpr_pkg::NBPR_CYC_READ}};
                        state_reg <= E_SETUP;
                    end
                E_SETUP:
                begin
                    // one cycle of qualifier setup before the strobe falls
                    o_we_n <= is_read_reg;
                    o_read_strobe_n <= !is_read_reg;
                    cnt_reg <= LOW_LOAD;
                    state_reg <= E_LOW;
                end
                E_LOW:
                    if (cnt_zero)
                    begin
                        o_we_n <= 1'b1;
                        o_read_strobe_n <= 1'b1;
                        cnt_reg <= HIGH_LOAD;
                        state_reg <= E_HIGH;
                    end
                    else
                        cnt_reg <= cnt_reg - 8'h01;
                E_HIGH:
                    if (cnt_zero)
                    begin
                        o_cle <= 1'b0;
                        o_ale <= 1'b0;
                        o_io_oe <= '0;
                        done_reg <= 1'b1;
                        state_reg <= E_IDLE;
                    end
                    else
                        cnt_reg <= cnt_reg - 8'h01;
                default:
                    state_reg <= E_IDLE;
            endcase
        end
    end
endmodule

// file: hdl/nbpr_host.sv
// host sequencer for nand page read and column change over the strobe bus
`timescale 1ns/100ps
module nbpr_host #(
    parameter int BUS_WIDTH = 8
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // user request
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire nbpr_pkg::nbpr_op_type i_cmd_op,
    input wire logic [nbpr_pkg::COL_BITS-1:0] i_column,
    input wire logic [nbpr_pkg::ROW_BITS-1:0] i_row,
    input wire logic [11:0] i_word_count,
    input wire logic i_allow_write,
    // user answer
    output logic o_rd_valid,
    output logic [BUS_WIDTH-1:0] o_rd_data,
    output logic o_done,
    output logic o_plane,
    // flash pins
    output logic o_chip_select_n,
    output logic o_cle,
    output logic o_ale,
    output logic o_we_n,
    output logic o_read_strobe_n,
    output logic o_write_protect_n,
    output logic o_whole_chip_protect,
    output logic [BUS_WIDTH-1:0] o_shared_io_bus,
    output logic [BUS_WIDTH-1:0] o_shared_io_bus_oe,
    input wire logic [BUS_WIDTH-1:0] i_shared_io_bus,
    input wire logic i_ready_busy
);
    // only byte and word buses have an address mapping
    if (BUS_WIDTH != 8 && BUS_WIDTH != 16)
    begin
        $error("bus width must be 8 or 16");
    end

    localparam bit WIDE = (BUS_WIDTH == 16);
    localparam int PAGE_WORDS = (nbpr_pkg::PAGE_MAIN_BYTES + nbpr_pkg::PAGE_SPARE_BYTES)
        / (WIDE ? 2 : 1);
    localparam logic [11:0] PAGE_WORDS_12 = 12'(PAGE_WORDS);
    localparam logic [7:0] BUSY_LOAD = 8'(nbpr_pkg::BUSY_START_CYC - 1);
    localparam logic [7:0] SETTLE_LOAD = 8'(nbpr_pkg::COLUMN_SETTLE_CYC - 1);

    typedef enum logic [2:0] {
        ST_IDLE, ST_ISSUE, ST_WAIT_CYCLE, ST_WAIT_BUSY, ST_WAIT_READY, ST_READ, ST_READ_WAIT
    } nbpr_state_type;

    // byte or word for each address cycle, upper byte always zero
    function automatic logic [15:0] addr_word(input logic [2:0] idx,
        input logic [nbpr_pkg::COL_BITS-1:0] col, input logic [nbpr_pkg::ROW_BITS-1:0] row);
        logic [15:0] w;
        w = 16'h0000;
        case (idx)
            3'h1: w = {8'h00, col[7:0]};
            3'h2: w = WIDE ? {13'h0000, col[10:8]} : {12'h000, col[11:8]};
            3'h3: w = {8'h00, row[7:0]};
            3'h4: w = {8'h00, row[15:8]};
            3'h5: w = {15'h0000, row[16]};
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    nbpr_state_type state_reg;
    nbpr_pkg::nbpr_op_type op_reg;
    logic [2:0] step_reg;
    logic [nbpr_pkg::COL_BITS-1:0] col_reg;
    logic [nbpr_pkg::ROW_BITS-1:0] row_reg;
    logic [11:0] left_reg;
    logic [7:0] wait_reg;
    logic ce_n_reg;
    logic rb_meta_reg;
    logic rb_sync_reg;
    logic wp_n_reg;
    logic rd_valid_reg;
    logic [BUS_WIDTH-1:0] rd_data_reg;
    logic done_reg;
    logic plane_reg;

    nbpr_cycle_if cyc ();

    wire is_col_change = (op_reg == nbpr_pkg::NBPR_OP_COLUMN_CHANGE);
    wire [7:0] cmd_byte = (step_reg == nbpr_pkg::STEP_CMD)
        ? (is_col_change ? nbpr_pkg::CMD_COLUMN_CHANGE : nbpr_pkg::CMD_PAGE_READ)
        : (is_col_change ? nbpr_pkg::CMD_COLUMN_CONFIRM : nbpr_pkg::CMD_READ_CONFIRM);
    wire step_is_cmd = (step_reg == nbpr_pkg::STEP_CMD) || (step_reg == nbpr_pkg::STEP_CONFIRM);
    // column change carries only the column cycles
    wire [2:0] step_after = (is_col_change && step_reg == nbpr_pkg::STEP_COL_LAST)
        ? nbpr_pkg::STEP_CONFIRM : step_reg + 3'h1;
    wire wait_zero = (wait_reg == 8'h00);
    wire [11:0] count_clip = (i_word_count == 12'h000 || i_word_count > PAGE_WORDS_12)
        ? PAGE_WORDS_12 : i_word_count;

    assign cyc.req = (state_reg == ST_ISSUE) || (state_reg == ST_READ);
    assign cyc.kind = (state_reg == ST_READ) ? nbpr_pkg::NBPR_CYC_READ
        : (step_is_cmd ? nbpr_pkg::NBPR_CYC_CMD : nbpr_pkg::NBPR_CYC_ADDR);
    assign cyc.wdata = step_is_cmd ? {8'h00, cmd_byte} : addr_word(step_reg, col_reg, row_reg);

    assign o_cmd_ready = (state_reg == ST_IDLE);
    assign o_chip_select_n = ce_n_reg;
    assign o_write_protect_n = wp_n_reg;
    assign o_rd_valid = rd_valid_reg;
    assign o_rd_data = rd_data_reg;
    assign o_done = done_reg;
    assign o_plane = plane_reg;

    nbpr_bus_cycle #(
        .BUS_WIDTH(BUS_WIDTH)
    ) u_engine (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .cyc(cyc),
        .o_cle(o_cle),
        .o_ale(o_ale),
        .o_we_n(o_we_n),
        .o_read_strobe_n(o_read_strobe_n),
        .o_io(o_shared_io_bus),
        .o_io_oe(o_shared_io_bus_oe),
        .i_io(i_shared_io_bus)
    );

    // ready/busy is a pin: two flops before use
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rb_meta_reg <= 1'b0;
            rb_sync_reg <= 1'b0;
        end
        else
        begin
            rb_meta_reg <= i_ready_busy;
            rb_sync_reg <= rb_meta_reg;
        end
    end

    // protect pins: write protect low through reset, chip lock kept off
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wp_n_reg <= 1'b0;
            o_whole_chip_protect <= 1'b0;
        end
        else
        begin
            wp_n_reg <= i_allow_write;
            o_whole_chip_protect <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_reg <= ST_IDLE;
            op_reg <= nbpr_pkg::NBPR_OP_PAGE_READ;
            step_reg <= nbpr_pkg::STEP_CMD;
            col_reg <= '0;
            row_reg <= '0;
            left_reg <= 12'h000;
            wait_reg <= nbpr_pkg::COUNT_RESET;
            ce_n_reg <= 1'b1;
            rd_valid_reg <= 1'b0;
            rd_data_reg <= '0;
            done_reg <= 1'b0;
            plane_reg <= 1'b0;
        end
        else
        begin
            rd_valid_reg <= 1'b0;
            done_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    ce_n_reg <= 1'b1;
                    if (i_cmd_valid)
                    begin
                        op_reg <= i_cmd_op;
                        col_reg <= WIDE ? {1'b0, i_column[10:0]} : i_column;
                        row_reg <= i_row;
                        plane_reg <= i_row[nbpr_pkg::PLANE_ROW_BIT];
                        left_reg <= count_clip;
                        step_reg <= nbpr_pkg::STEP_CMD;
                        ce_n_reg <= 1'b0;
                        state_reg <= ST_ISSUE;
                    end
                end
                ST_ISSUE:
                    state_reg <= ST_WAIT_CYCLE;
                ST_WAIT_CYCLE:
                    if (cyc.done)
                    begin
                        if (step_reg == nbpr_pkg::STEP_CONFIRM)
                        begin
                            wait_reg <= is_col_change ? SETTLE_LOAD : BUSY_LOAD;
                            state_reg <= ST_WAIT_BUSY;
                        end
                        else
                        begin
                            step_reg <= step_after;
                            state_reg <= ST_ISSUE;
                        end
                    end
                ST_WAIT_BUSY:
                    if (wait_zero)
                    begin
                        state_reg <= is_col_change ? ST_READ : ST_WAIT_READY;
                        // chip select may drop during latency; the read carries on
                        ce_n_reg <= !is_col_change;
                    end
                    else
                        wait_reg <= wait_reg - 8'h01;
                ST_WAIT_READY:
                    if (rb_sync_reg)
                    begin
                        ce_n_reg <= 1'b0;
                        state_reg <= ST_READ;
                    end
                ST_READ:
                    state_reg <= ST_READ_WAIT;
                ST_READ_WAIT:
                    if (cyc.done)
                    begin
                        rd_valid_reg <= 1'b1;
                        rd_data_reg <= cyc.rdata[BUS_WIDTH-1:0];
                        left_reg <= left_reg - 12'h001;
                        if (left_reg == 12'h001)
                        begin
                            done_reg <= 1'b1;
                            ce_n_reg <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                        else
                            state_reg <= ST_READ;
                    end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule

// file: bench/nbpr_flash_model.sv
// behavioural byte-wide flash device answering the page read host
`timescale 1ns/100ps
module nbpr_flash_model #(
    parameter int BUSY_NS = 400
) (
    // host strobes
    input wire logic i_chip_select_n,
    input wire logic i_cle,
    input wire logic i_ale,
    input wire logic i_we_n,
    input wire logic i_read_strobe_n,
    input wire logic i_whole_chip_protect,
    input wire logic [7:0] i_io,
    // device answers
    output logic [7:0] o_io,
    output logic o_busy_pull,
    output int o_errs
);
    logic [7:0] addr_q[$];
    logic [7:0] last_cmd = 8'hff;
    logic [7:0] word_reg = 8'h5a;
    logic [11:0] col_reg = 12'h000;
    logic [16:0] row_reg = 17'h00000;
    event busy_ev;
    initial o_errs = 0;
    initial o_busy_pull = 1'b0;
    // deselected bus floats: show the inverse so a stale word cannot pass
    assign o_io = i_chip_select_n ? ~word_reg : word_reg;
    // busy time runs on regardless of chip select
    always @(busy_ev)
    begin
        #BUSY_NS;
        o_busy_pull = 1'b0;
    end
    always @(posedge i_we_n)
    begin
        if (!i_chip_select_n)
        begin
            if (i_cle == i_ale || i_whole_chip_protect)
                o_errs++;
            else if (i_ale)
                addr_q.push_back(i_io);
            else
                take_cmd(i_io);
        end
    end
    task automatic take_cmd(input logic [7:0] c);
        if (c == 8'h00 || c == 8'h05)
            addr_q.delete();
        else if (c == 8'h30 && last_cmd == 8'h00 && addr_q.size() == 5)
        begin
            if (addr_q[1][7:4] != 4'h0 || addr_q[4][7:1] != 7'h00)
                o_errs++;
            col_reg = {addr_q[1][3:0], addr_q[0]};
            row_reg = {addr_q[4][0], addr_q[3], addr_q[2]};
            o_busy_pull = 1'b1;
            -> busy_ev;
        end
        else if (c == 8'he0 && last_cmd == 8'h05 && addr_q.size() == 2)
            col_reg = {addr_q[1][3:0], addr_q[0]};
        else
            o_errs++;
        last_cmd = c;
    endtask
    always @(negedge i_read_strobe_n)
    begin
        if (i_chip_select_n || o_busy_pull)
            o_errs++;
        word_reg <= #8 col_reg[7:0] ^ row_reg[7:0];
        col_reg = col_reg + 12'h001;
    end
endmodule

// file: bench/nbpr_host_asserts.sv
// concurrent checks on the pins and answers of the page read host
`timescale 1ns/100ps
module nbpr_host_asserts #(
    parameter int BUS_WIDTH = 8
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // user side
    input wire logic i_allow_write,
    input wire logic o_rd_valid,
    input wire logic o_done,
    // flash pins
    input wire logic o_chip_select_n,
    input wire logic o_cle,
    input wire logic o_ale,
    input wire logic o_we_n,
    input wire logic o_read_strobe_n,
    input wire logic o_write_protect_n,
    input wire logic o_whole_chip_protect,
    input wire logic [BUS_WIDTH-1:0] o_shared_io_bus,
    input wire logic [BUS_WIDTH-1:0] o_shared_io_bus_oe,
    input wire logic i_ready_busy
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    a_qual_exclusive: assert property (!(o_cle && o_ale))
        else $error("both latch qualifiers high");
    a_we_qualified: assert property ($fell(o_we_n) |-> o_cle ^ o_ale && &o_shared_io_bus_oe)
        else $error("write strobe without one qualifier or bus drive");
    a_we_pulse: assert property ($fell(o_we_n) |=> !o_we_n [*2] ##1 (o_we_n && $stable(o_shared_io_bus)))
        else $error("write strobe width or data hold wrong");
    a_re_low: assert property ($fell(o_read_strobe_n) |=> !o_read_strobe_n [*2] ##1 o_read_strobe_n)
        else $error("read strobe low phase wrong");
    a_re_high: assert property ($rose(o_read_strobe_n) |-> o_read_strobe_n [*3])
        else $error("read strobe high phase too short");
    a_read_ready: assert property ($fell(o_read_strobe_n) |-> i_ready_busy && !o_chip_select_n)
        else $error("read strobe while busy or deselected");
    a_read_no_drive: assert property (!o_read_strobe_n |-> o_shared_io_bus_oe == '0)
        else $error("bus driven during read");
    a_wp_follow: assert property ($past(i_rstn) |-> o_write_protect_n == $past(i_allow_write))
        else $error("write protect does not follow request");
    a_chip_unlock: assert property (!o_whole_chip_protect)
        else $error("whole chip protect driven high");
    a_done_last: assert property (o_done |-> o_rd_valid)
        else $error("done without read word");
    c_done: cover property (o_done);
    c_cmd: cover property ($rose(o_cle));
    c_stream: cover property (o_rd_valid && !o_done);
endmodule
bind nbpr_host nbpr_host_asserts #(.BUS_WIDTH(BUS_WIDTH)) u_host_asserts (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_allow_write(i_allow_write),
    .o_rd_valid(o_rd_valid),
    .o_done(o_done),
    .o_chip_select_n(o_chip_select_n),
    .o_cle(o_cle),
    .o_ale(o_ale),
    .o_we_n(o_we_n),
    .o_read_strobe_n(o_read_strobe_n),
    .o_write_protect_n(o_write_protect_n),
    .o_whole_chip_protect(o_whole_chip_protect),
    .o_shared_io_bus(o_shared_io_bus),
    .o_shared_io_bus_oe(o_shared_io_bus_oe),
    .i_ready_busy(i_ready_busy)
);

// file: bench/nbpr_tb_top.sv
// self-checking bench: page read host against the flash model
`timescale 1ns/100ps
module nbpr_host_tb_top;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic i_cmd_valid = 1'b0;
    logic i_allow_write = 1'b0;
    nbpr_pkg::nbpr_op_type i_cmd_op = nbpr_pkg::NBPR_OP_PAGE_READ;
    logic [11:0] i_column = 12'h000;
    logic [16:0] i_row = 17'h00000;
    logic [11:0] i_word_count = 12'h001;
    logic o_cmd_ready, o_rd_valid, o_done, o_plane, ce_n, cle, ale, we_n, re_n, wp_n, pt, busy;
    logic [7:0] o_rd_data, io, oe, fl_io, bus_in;
    logic [7:0] exp_q[$];
    logic [16:0] cur_row;
    int errs, fails = 0, check_count = 0, done_seen = 0, seed = 59966;
    always #2 i_clock = ~i_clock;
    // bus pins: host value where driven, flash word otherwise
    assign bus_in = (oe & io) | (~oe & fl_io);
    nbpr_host DUT (.i_clock(i_clock), .i_rstn(i_rstn), .i_cmd_valid(i_cmd_valid),
        .o_cmd_ready(o_cmd_ready), .i_cmd_op(i_cmd_op), .i_column(i_column), .i_row(i_row),
        .i_word_count(i_word_count), .i_allow_write(i_allow_write), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .o_done(o_done), .o_plane(o_plane), .o_chip_select_n(ce_n),
        .o_cle(cle), .o_ale(ale), .o_we_n(we_n), .o_read_strobe_n(re_n),
        .o_write_protect_n(wp_n), .o_whole_chip_protect(pt), .o_shared_io_bus(io),
        .o_shared_io_bus_oe(oe), .i_shared_io_bus(bus_in), .i_ready_busy(~busy));
    nbpr_flash_model u_flash (.i_chip_select_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n),
        .i_read_strobe_n(re_n), .i_whole_chip_protect(pt), .i_io(io), .o_io(fl_io),
        .o_busy_pull(busy), .o_errs(errs));
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic run(input nbpr_pkg::nbpr_op_type op, input logic [11:0] col,
            input logic [16:0] row, input logic [11:0] cnt);
        int n;
        int d;
        n = (cnt == 0 || cnt > 2112) ? 2112 : cnt;
        if (op == nbpr_pkg::NBPR_OP_PAGE_READ)
            cur_row = row;
        for (int k = 0; k < n; k++)
            exp_q.push_back(8'(col + k) ^ cur_row[7:0]);
        d = done_seen;
        i_cmd_valid <= 1'b1;
        i_cmd_op <= op;
        i_column <= col;
        i_row <= row;
        i_word_count <= cnt;
        @(posedge i_clock);
        while (o_cmd_ready !== 1'b1)
            @(posedge i_clock);
        i_cmd_valid <= 1'b0;
        for (int t = 0; t < 20000 && done_seen == d; t++)
            @(posedge i_clock);
        cmp_bit(done_seen != d, 1'b1);
        if (op == nbpr_pkg::NBPR_OP_PAGE_READ)
            cmp_bit(o_plane, row[nbpr_pkg::PLANE_ROW_BIT]);
    endtask
    // results come back in request order; sampled mid-cycle, clear of the launch edge
    always @(negedge i_clock)
    begin
        if (o_rd_valid === 1'b1)
        begin
            cmp_byte(o_rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
            if (o_done === 1'b1)
            begin
                cmp_bit(exp_q.size() == 0, 1'b1);
                done_seen++;
            end
        end
    end
    initial
    begin
        repeat (2) @(posedge i_clock);
        i_rstn <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            i_allow_write <= 1'($random(seed));
            run(nbpr_pkg::NBPR_OP_PAGE_READ, 12'($random(seed)) & 12'h7ff,
                17'($random(seed)), 12'(1 + ($random(seed) & 15)));
            cmp_bit(wp_n, i_allow_write);
            run(nbpr_pkg::NBPR_OP_COLUMN_CHANGE, 12'($random(seed)) & 12'h7ff,
                17'h00000, 12'(1 + ($random(seed) & 15)));
            $display("test read pair %0d done", i);
        end
        run(nbpr_pkg::NBPR_OP_PAGE_READ, 12'h000, 17'h1ffff, 12'h000);
        $display("test whole page done");
        cmp_bit(errs == 0, 1'b1);
        finish_test();
    end
    // whole run needs about 20k cycles
    initial
    begin
        #240000;
        fails++;
        finish_test();
    end
endmodule
